// ==== pkg/nv_pkg.sv ====
// Constants and types for the byte-wide nonvolatile store controller
package nv_pkg;
   // Array size, largest variant; address width follows from it
   localparam int NV_BYTES = 512;
   localparam int NV_AW = 9;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // Register byte offsets on the APB
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_ADDR = 12'h004;
   localparam logic [11:0] OFS_DATA = 12'h008;

   // Control register fields
   localparam int CTRL_READ = 0;
   localparam int CTRL_STROBE = 1;
   localparam int CTRL_ARM = 2;
   localparam int CTRL_MODE_LO = 4;

   // Programming mode codes
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;

   // Reset values
   localparam logic [8:0] ADDR_RESET = 9'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h0;

   // Cycle counts: arm window and processor halts
   localparam logic [2:0] ARM_WINDOW = 3'h4;
   localparam logic [2:0] READ_HALT = 3'h4;
   localparam logic [2:0] PROG_HALT = 3'h2;

   // Self-timed programming times in microseconds, at the 100 MHz clock
   localparam int CLK_MHZ = 100;
   localparam int ERASE_TIME_US = 1800;
   localparam int WRITE_TIME_US = 1800;
   localparam int ATOMIC_TIME_US = 3400;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
   localparam int ATOMIC_CYCLES = ATOMIC_TIME_US * CLK_MHZ;

   // Programming sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ERASE = 2'h1,
      ST_BOTH = 2'h3,
      ST_WRITE = 2'h2
   } pg_state_t;
endpackage

// ==== rtl/nv_byte_ctrl.sv ====
// APB controller for a byte-programmable nonvolatile data store
`timescale 1ns/1ns

// How it works
// (RULE1) Store is its own byte-addressed space of 512 bytes, each byte separately.
// (RULE2) Address, data and control registers sit in the processor's register space.
// (RULE3) A store read halts the processor four extra cycles; two when the same control write also starts programming.
// (RULE4) Starting a programming operation halts the processor two extra cycles.
// (RULE5) Software loads address, and data when writing, before starting programming.
// (RULE6) Mode zero: armed strobe within four cycles does one erase-and-write.
// (RULE7) Mode 01: armed strobe erases the addressed byte only.
// (RULE8) Mode 10: armed strobe writes the data register without erasing.
// (RULE9) The strobe bit reads set until the self-timed operation ends.
// (RULE10) While programming runs, no other store access is started.
// (RULE11) Software erases a byte before write-only mode, else data is lost.
// (RULE12) The arm bit clears itself four cycles after being set.
// (RULE13) A read loads the addressed byte into data register; ignored while busy.
module nv_byte_ctrl #(
   parameter int unsigned ERASE_CYCLES = nv_pkg::ERASE_CYCLES,
   parameter int unsigned WRITE_CYCLES = nv_pkg::WRITE_CYCLES,
   parameter int unsigned ATOMIC_CYCLES = nv_pkg::ATOMIC_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Register state
   logic [8:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic [1:0] mode_q, mode_d;
   logic [2:0] arm_q, arm_d;
   logic [2:0] stall_q, stall_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic [19:0] cnt_q, cnt_d;
   nv_pkg::pg_state_t st_q, st_d;

   // Array and its write port
   logic [7:0] mem_q [nv_pkg::NV_BYTES];
   logic mem_we;
   logic [7:0] mem_wd;
   logic [7:0] rd_byte;

   // Decode helpers
   logic acc_first, wr, hit_ctrl, hit_addr, hit_data, busy, arm_act;
   logic rd_go, go, arm_set;

   assign busy = (st_q != nv_pkg::ST_IDLE);
   assign arm_act = (arm_q != 3'h0);
   assign rd_byte = mem_q[addr_q];

   // First access cycle: all register effects land here, once per transfer
   assign acc_first = psel && penable && (stall_q == 3'h0);
   assign wr = acc_first && pwrite;
   assign hit_ctrl = (paddr == nv_pkg::OFS_CTRL);
   assign hit_addr = (paddr == nv_pkg::OFS_ADDR);
   assign hit_data = (paddr == nv_pkg::OFS_DATA);

   // Requests carried by a control write; busy blocks the read and the strobe, not the arm
   assign rd_go = wr && hit_ctrl && pwdata[nv_pkg::CTRL_READ] && !busy; // RULE10 RULE13
   assign go = wr && hit_ctrl && pwdata[nv_pkg::CTRL_STROBE] && arm_act && !busy
      && (mode_q != 2'h3); // RULE6 RULE10
   assign arm_set = wr && hit_ctrl && pwdata[nv_pkg::CTRL_ARM];

   // Handshake: ready on the last cycle of the stretched access
   assign pready = psel && penable && (stall_q == 3'h1);
   assign prdata = rdata_q;
   assign pslverr = pready && err_q;

   // Register file, read mux and the processor halt
   always_comb begin
      addr_d = addr_q;
      data_d = data_q;
      mode_d = mode_q;
      rdata_d = rdata_q;
      err_d = err_q;
      stall_d = (stall_q != 3'h0) ? stall_q - 3'h1 : 3'h0;
      if (acc_first) begin
         stall_d = 3'h1;
         err_d = 1'b0;
         rdata_d = 32'h0000_0000;
         // Offsets decoded in order; anything else is an error
         if (hit_ctrl) begin // RULE2
            rdata_d[nv_pkg::CTRL_STROBE] = busy; // RULE9
            rdata_d[nv_pkg::CTRL_ARM] = arm_act;
            rdata_d[nv_pkg::CTRL_MODE_LO +: 2] = mode_q;
            if (pwrite && !busy) begin
               mode_d = pwdata[nv_pkg::CTRL_MODE_LO +: 2];
            end
         end else if (hit_addr) begin
            rdata_d[8:0] = addr_q;
            // Writes during programming would corrupt the target byte
            if (pwrite && !busy) begin
               addr_d = pwdata[8:0]; // RULE1
            end
         end else if (hit_data) begin
            rdata_d[7:0] = data_q;
            if (pwrite && !busy) begin
               data_d = pwdata[7:0];
            end
         end else begin
            err_d = 1'b1;
         end
         if (rd_go) begin
            data_d = rd_byte; // RULE13
            stall_d = nv_pkg::READ_HALT + 3'h1; // RULE3
         end
         if (go) begin
            stall_d = nv_pkg::PROG_HALT + 3'h1; // RULE4
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= nv_pkg::ADDR_RESET;
         data_q <= nv_pkg::DATA_RESET;
         mode_q <= nv_pkg::MODE_RESET;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
         stall_q <= 3'h0;
      end else begin
         addr_q <= addr_d;
         data_q <= data_d;
         mode_q <= mode_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
         stall_q <= stall_d;
      end
   end

   // Arm window counter; a fresh arm restarts the window
   always_comb begin
      arm_d = (arm_q != 3'h0) ? arm_q - 3'h1 : 3'h0; // RULE12
      if (arm_set) begin
         arm_d = nv_pkg::ARM_WINDOW; // RULE6
      end
      if (go) begin
         arm_d = 3'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= 3'h0;
      end else begin
         arm_q <= arm_d;
      end
   end

   // Self-timed sequencer; the array is only touched when the timer ends
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      mem_we = 1'b0;
      mem_wd = rd_byte;
      case (st_q)
         nv_pkg::ST_IDLE: begin
            if (go) begin
               case (mode_q)
                  nv_pkg::MODE_ERASE: begin
                     st_d = nv_pkg::ST_ERASE; // RULE7
                     cnt_d = 20'(ERASE_CYCLES);
                  end
                  nv_pkg::MODE_WRITE: begin
                     st_d = nv_pkg::ST_WRITE; // RULE8
                     cnt_d = 20'(WRITE_CYCLES);
                  end
                  default: begin
                     st_d = nv_pkg::ST_BOTH; // RULE6
                     cnt_d = 20'(ATOMIC_CYCLES);
                  end
               endcase
            end
         end
         default: begin
            cnt_d = cnt_q - 20'h00001;
            if (cnt_q == 20'h00001) begin
               st_d = nv_pkg::ST_IDLE; // RULE9
               mem_we = 1'b1;
               if (st_q == nv_pkg::ST_ERASE) begin
                  mem_wd = nv_pkg::ERASED_BYTE; // RULE7
               end else if (st_q == nv_pkg::ST_WRITE) begin
                  // Cells only lose ones without an erase
                  mem_wd = rd_byte & data_q; // RULE8
               end else begin
                  mem_wd = data_q; // RULE6
               end
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= nv_pkg::ST_IDLE;
         cnt_q <= 20'h00000;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // Array keeps its content across reset, as the real store would
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem_q[addr_q] <= mem_wd; // RULE1
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   read_halt_a: assert property (rd_go |-> !pready [*5] ##1 pready) // RULE3
      else $error("read did not halt the bus four extra cycles");

   prog_halt_a: assert property (go |-> !pready [*3] ##1 pready) // RULE4
      else $error("program start did not halt the bus two extra cycles");

   arm_expire_a: assert property (arm_set ##1 (!arm_set) [*4] |=> !arm_act) // RULE12
      else $error("arm bit outlived its window");

   no_arm_a: assert property (wr && hit_ctrl && pwdata[nv_pkg::CTRL_STROBE] && !arm_act
      && !busy |=> st_q == nv_pkg::ST_IDLE) // RULE6
      else $error("unarmed strobe started programming");

   busy_flag_a: assert property (go |=> busy [*8]) // RULE9
      else $error("strobe bit dropped early");

   refuse_a: assert property (busy && acc_first && pwrite && cnt_q != 20'h00001
      |=> $stable(data_q) && $stable(addr_q) && $stable(mode_q) && busy) // RULE10
      else $error("access taken while programming");

   read_load_a: assert property (rd_go |=> data_q == $past(rd_byte)) // RULE13
      else $error("read did not load the data register");

   erase_end_a: assert property (st_q == nv_pkg::ST_ERASE && cnt_q == 20'h00001
      |=> rd_byte == nv_pkg::ERASED_BYTE && !busy) // RULE7
      else $error("erase did not leave the byte blank");

   write_end_a: assert property (st_q == nv_pkg::ST_WRITE && cnt_q == 20'h00001
      |=> rd_byte == ($past(rd_byte) & $past(data_q))) // RULE8
      else $error("write-only result wrong");

   atomic_end_a: assert property (st_q == nv_pkg::ST_BOTH && cnt_q == 20'h00001
      |=> rd_byte == $past(data_q)) // RULE6
      else $error("erase-and-write result wrong");

endmodule

// ==== tb/apb_cpu.sv ====
// APB master standing in for the processor core
`timescale 1ns/1ns
module apb_cpu (
   // Clock
   input wire logic pclk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // APB answer
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer; n counts access cycles up to pready, capped so a hang ends
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e, output int n);
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Answer looked at mid-cycle, settled; it stands through the edge that takes it
      do begin
         @(negedge pclk);
         rdy = pready;
         r = prdata;
         e = pslverr;
         @(posedge pclk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the nonvolatile byte store controller
`timescale 1ns/1ns
module tb;
   // Short programming times keep the run brief
   localparam int ECYC = 24;
   localparam int WCYC = 28;
   localparam int ACYC = 40;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [31:0] seed = 32'h0000f54e;
   int n;
   int cyc = 0;
   int error_cnt = 0;
   int num_checks = 0;

   always #5 pclk = ~pclk;

   nv_byte_ctrl #(.ERASE_CYCLES(ECYC), .WRITE_CYCLES(WCYC), .ATOMIC_CYCLES(ACYC)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   apb_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Byte left in the array after programming old with d
   function automatic logic [7:0] exp_byte(logic [1:0] m, logic [7:0] old, logic [7:0] d);
      case (m)
         nv_pkg::MODE_ATOMIC: return d;
         nv_pkg::MODE_ERASE: return nv_pkg::ERASED_BYTE;
         default: return old & d;
      endcase
   endfunction

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, r, e, n);
   endtask

   task automatic rd(input logic [11:0] a);
      cpu.xfer(1'b0, a, 32'h0, r, e, n);
   endtask

   // Poll busy with a bound, since a stuck strobe would hang here
   task automatic wait_idle();
      for (int i = 0; i < 40; i++) begin
         rd(nv_pkg::OFS_CTRL);
         if (r[nv_pkg::CTRL_STROBE] === 1'b0) break;
      end
      chk(32'(r[nv_pkg::CTRL_STROBE]), 32'h0);
   endtask

   // Load, arm, strobe; w waits for the end and checks the busy time
   task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                       input bit w);
      int c0;
      int c;
      c = (m == nv_pkg::MODE_ERASE) ? ECYC : (m == nv_pkg::MODE_WRITE) ? WCYC : ACYC;
      wr(nv_pkg::OFS_ADDR, {23'h0, a});
      wr(nv_pkg::OFS_DATA, {24'h0, d});
      wr(nv_pkg::OFS_CTRL, {26'h0, m, 4'h4});
      wr(nv_pkg::OFS_CTRL, {26'h0, m, 4'h2});
      chk(32'(n), 32'h4);
      c0 = cyc;
      rd(nv_pkg::OFS_CTRL);
      chk(32'(r[nv_pkg::CTRL_STROBE]), 32'h1);
      if (w) begin
         wait_idle();
         chk(32'(cyc - c0 + 3 >= c), 32'h1);
      end
   endtask

   task automatic get(input logic [8:0] a, input logic [7:0] exp);
      wr(nv_pkg::OFS_ADDR, {23'h0, a});
      wr(nv_pkg::OFS_CTRL, 32'h1);
      chk(32'(n), 32'h6);
      rd(nv_pkg::OFS_DATA);
      chk(r, {24'h0, exp});
   endtask

   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end

   initial begin
      logic [8:0] a;
      logic [7:0] d;
      logic [7:0] top;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, then an unmapped place
      rd(nv_pkg::OFS_ADDR);
      chk(r, 32'h0);
      rd(nv_pkg::OFS_CTRL);
      chk(r, 32'h0);
      chk(32'(e), 32'h0);
      rd(12'h00c);
      chk(32'(e), 32'h1);
      // Every mode on both ends of the space and random places
      for (int k = 0; k < 4; k++) begin
         a = (k == 0) ? 9'h1ff : (k == 1) ? 9'h000 : 9'(rnd());
         d = 8'(rnd());
         prog(nv_pkg::MODE_ATOMIC, a, d, 1'b1);
         get(a, exp_byte(nv_pkg::MODE_ATOMIC, 8'h00, d));
         prog(nv_pkg::MODE_ERASE, a, ~d, 1'b1);
         get(a, exp_byte(nv_pkg::MODE_ERASE, d, ~d));
         d = 8'(rnd());
         prog(nv_pkg::MODE_WRITE, a, d, 1'b1);
         get(a, exp_byte(nv_pkg::MODE_WRITE, nv_pkg::ERASED_BYTE, d));
         if (a == 9'h1ff) top = d;
      end
      get(9'h1ff, top);
      // Accesses while busy change no register but the arm bit and add no halt
      prog(nv_pkg::MODE_ATOMIC, 9'h0a5, 8'h3c, 1'b0);
      wr(nv_pkg::OFS_ADDR, 32'h011);
      wr(nv_pkg::OFS_DATA, 32'hc3);
      wr(nv_pkg::OFS_CTRL, 32'h1);
      chk(32'(n), 32'h2);
      wr(nv_pkg::OFS_CTRL, 32'h4);
      wr(nv_pkg::OFS_CTRL, 32'h2);
      chk(32'(n), 32'h2);
      wait_idle();
      rd(nv_pkg::OFS_ADDR);
      chk(r, 32'h0a5);
      rd(nv_pkg::OFS_DATA);
      chk(r, 32'h3c);
      // Strobe after the arm window has lapsed
      wr(nv_pkg::OFS_CTRL, 32'h4);
      repeat (5) @(posedge pclk);
      wr(nv_pkg::OFS_CTRL, 32'h2);
      chk(32'(n), 32'h2);
      rd(nv_pkg::OFS_CTRL);
      chk(32'(r[nv_pkg::CTRL_STROBE]), 32'h0);
      // Reserved mode: an armed strobe starts nothing
      wr(nv_pkg::OFS_CTRL, 32'h34);
      wr(nv_pkg::OFS_CTRL, 32'h32);
      chk(32'(n), 32'h2);
      rd(nv_pkg::OFS_CTRL);
      chk(r, 32'h30);
      get(9'h0a5, 8'h3c);
      // Reset in mid-erase aborts it; the array keeps its old byte
      prog(nv_pkg::MODE_ERASE, 9'h0a5, 8'h00, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(nv_pkg::OFS_CTRL);
      chk(r, 32'h0);
      get(9'h0a5, 8'h3c);
      conclude();
   end
endmodule
